// ---- hw/cmo_defs.vh ----
// Operation
// [RULE_01] code byte load: A gets code byte at 16-bit base plus unsigned A
// [RULE_02] pc base advances to next instruction first; pointer base stays; no flags change
// [RULE_03] pc-based code byte load is one byte, two machine cycles
// [RULE_04] external move copies one byte between A and external data memory
// [RULE_05] indirect external move puts index register value on low port, then data
// [RULE_06] pointer external move: high byte on high port, low byte muxed with data
// [RULE_07] high port latch keeps its value while pointer high byte is driven
// [RULE_08] every external move form is one byte, two machine cycles
// [RULE_09] multiply forms unsigned product of A and B in four machine cycles
// [RULE_10] product low byte goes to A, high byte to B
// [RULE_11] multiply sets overflow when product above 255, always clears carry
// [RULE_12] idle instruction only advances pc by one, one cycle
// [RULE_13] byte or writes bitwise or of operands to destination, no flags
// [RULE_14] A destination takes register, direct, indirect or immediate; direct takes A or immediate
// [RULE_15] or into a port reads that port's output latch, not its pins
// [RULE_16] direct-immediate or is three bytes two cycles; A register/direct/indirect one cycle
// [RULE_17] bit or sets carry when source is one, else keeps it; two cycles
// [RULE_18] complemented bit or uses inverted bit and leaves the bit unchanged
// [RULE_19] pop reads ram at stack pointer, decrements it, writes direct byte; two cycles
// [RULE_20] popping into the stack pointer: decrement first, popped value then wins
// [RULE_21] push increments stack pointer, then stores direct byte there; no flags
// [RULE_22] each instruction is decoded from its opcode; operand bytes fetched by length
// [RULE_23] external memory latches low address before data, moves byte under strobes
`ifndef CMO_DEFS_VH
`define CMO_DEFS_VH

// clocks per machine cycle and external access phases
`define CMO_MC_CLKS     7'd12
`define CMO_XM_ALE_END  3'd1
`define CMO_XM_STB      3'd2
`define CMO_XM_END      3'd6
`define CMO_XM_REL      3'd7

// opcodes
`define CMO_OP_CODE_DP  8'h93
`define CMO_OP_CODE_PC  8'h83
`define CMO_OP_XRD_DP   8'hE0
`define CMO_OP_XRD_RI   8'b1110_001?
`define CMO_OP_XWR_DP   8'hF0
`define CMO_OP_XWR_RI   8'b1111_001?
`define CMO_OP_MUL      8'hA4
`define CMO_OP_IDLE     8'h00
`define CMO_OP_OR_ARN   8'b0100_1???
`define CMO_OP_OR_ADIR  8'h45
`define CMO_OP_OR_ARI   8'b0100_011?
`define CMO_OP_OR_AIMM  8'h44
`define CMO_OP_OR_DA    8'h42
`define CMO_OP_OR_DIMM  8'h43
`define CMO_OP_OR_CBIT  8'h72
`define CMO_OP_OR_CNBIT 8'hA0
`define CMO_OP_POP      8'hD0
`define CMO_OP_PUSH     8'hC0

// special function register addresses
`define CMO_SFR_A       8'hE0
`define CMO_SFR_B       8'hF0
`define CMO_SFR_PSW     8'hD0
`define CMO_SFR_SP      8'h81
`define CMO_SFR_DPL     8'h82
`define CMO_SFR_DPH     8'h83
`define CMO_SFR_P1      8'h90
`define CMO_SFR_P2      8'hA0

// flag positions and reset values
`define CMO_PSW_CY      7
`define CMO_PSW_OV      2
`define CMO_SP_RST      8'h07
`define CMO_PORT_RST    8'hFF

// apb register offsets
`define CMO_REG_CTRL    8'h00
`define CMO_REG_CORE    8'h04
`define CMO_REG_PTRS    8'h08
`define CMO_REG_PORTS   8'h0C

`endif

// ---- hw/cmo_core.v ----
`timescale 1ns/10ps
`include "cmo_defs.vh"

module cmo_core (
  // clock and reset
  input  wire        clk,
  input  wire        nrst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // program memory, synchronous read, one clock latency
  output reg  [15:0] code_addr,
  input  wire [7:0]  code_data,
  // external data bus
  output reg  [7:0]  low_addr_data_port_o,
  output reg         low_addr_data_port_oe,
  input  wire [7:0]  low_addr_data_port_i,
  output reg  [7:0]  high_address_port,
  output reg         addr_latch_en,
  output reg         rd_n,
  output reg         wr_n,
  // general port
  output reg  [7:0]  port1_o,
  input  wire [7:0]  port1_i
);

// ==========================================================
// state encodings
localparam ST_ADDR = 3'd0;
localparam ST_GAP  = 3'd1;
localparam ST_TAKE = 3'd2;
localparam ST_EXEC = 3'd3;
localparam ST_CODE = 3'd4;
localparam ST_XMEM = 3'd5;
localparam ST_DONE = 3'd6;

// ==========================================================
// decode: {byte count, machine cycles}
function [4:0] cmo_info;
  input [7:0] op;
  begin
    casez (op)
      `CMO_OP_CODE_DP, `CMO_OP_CODE_PC : cmo_info = {2'd1, 3'd2}; // [RULE_03]
      `CMO_OP_XRD_DP, `CMO_OP_XRD_RI   : cmo_info = {2'd1, 3'd2}; // [RULE_08]
      `CMO_OP_XWR_DP, `CMO_OP_XWR_RI   : cmo_info = {2'd1, 3'd2}; // [RULE_08]
      `CMO_OP_MUL                      : cmo_info = {2'd1, 3'd4}; // [RULE_09]
      `CMO_OP_IDLE                     : cmo_info = {2'd1, 3'd1}; // [RULE_12]
      `CMO_OP_OR_ARN, `CMO_OP_OR_ARI   : cmo_info = {2'd1, 3'd1}; // [RULE_16]
      `CMO_OP_OR_ADIR, `CMO_OP_OR_AIMM : cmo_info = {2'd2, 3'd1}; // [RULE_16]
      `CMO_OP_OR_DA                    : cmo_info = {2'd2, 3'd1};
      `CMO_OP_OR_DIMM                  : cmo_info = {2'd3, 3'd2}; // [RULE_16]
      `CMO_OP_OR_CBIT, `CMO_OP_OR_CNBIT: cmo_info = {2'd2, 3'd2}; // [RULE_17]
      `CMO_OP_POP, `CMO_OP_PUSH        : cmo_info = {2'd2, 3'd2}; // [RULE_19]
      default                          : cmo_info = {2'd1, 3'd1};
    endcase
  end
endfunction

// ==========================================================
// architectural state
reg  [7:0]  iram [0:255];
reg  [15:0] pc_q;
reg  [7:0]  acc_q;
reg  [7:0]  b_q;
reg  [7:0]  psw_q;
reg  [7:0]  sp_q;
reg  [7:0]  dpl_q;
reg  [7:0]  dph_q;
reg  [7:0]  p2_q;
reg         run_q;
// sequencer
reg  [2:0]  st_q;
reg  [6:0]  cnt_q;
reg  [1:0]  idx_q;
reg  [7:0]  op_q;
reg  [7:0]  opr1_q;
reg  [7:0]  opr2_q;
reg  [1:0]  len_q;
reg  [2:0]  cyc_q;
reg  [2:0]  sub_q;
reg         xdp_q;
// internal ram write port, one clock behind the sequencer
reg         iw_en_q;
reg  [7:0]  iw_a_q;
reg  [7:0]  iw_d_q;
// pin synchronisers
reg  [7:0]  lad_s1_q;
reg  [7:0]  lad_s2_q;
reg  [7:0]  p1_s1_q;
reg  [7:0]  p1_s2_q;

// ==========================================================
// operand selection
wire [1:0]  bank     = psw_q[4:3];
wire [7:0]  rn_val   = iram[{3'b000, bank, op_q[2:0]}];
wire [7:0]  ri_val   = iram[{3'b000, bank, 2'b00, op_q[0]}];
wire [7:0]  at_ri    = iram[ri_val];
wire [7:0]  at_sp    = iram[sp_q];
wire        is_bitop = (op_q == `CMO_OP_OR_CBIT) || (op_q == `CMO_OP_OR_CNBIT);
wire        is_rmw   = (op_q == `CMO_OP_OR_DA) || (op_q == `CMO_OP_OR_DIMM);
wire [7:0]  bit_byte = opr1_q[7] ? {opr1_q[7:3], 3'b000} : {4'b0010, opr1_q[6:3]};
wire [7:0]  dsel     = is_bitop ? bit_byte : opr1_q;
wire [15:0] data_pointer     = {dph_q, dpl_q};
wire [15:0] prod     = acc_q * b_q;
wire [4:0]  info_new = cmo_info(code_data);
wire [6:0]  inst_clks = cyc_q * `CMO_MC_CLKS;
wire [6:0]  last_clk = inst_clks - 7'd1;
reg  [7:0]  dir_val;
reg         bit_val;

// direct byte read; P1 reads pins unless read-modify-write, P2 always reads its latch
always @*
begin
  dir_val = 8'h00;
  if (!dsel[7])
    dir_val = iram[dsel];
  else
    case (dsel)
      `CMO_SFR_A   : dir_val = acc_q;
      `CMO_SFR_B   : dir_val = b_q;
      `CMO_SFR_PSW : dir_val = psw_q;
      `CMO_SFR_SP  : dir_val = sp_q;
      `CMO_SFR_DPL : dir_val = dpl_q;
      `CMO_SFR_DPH : dir_val = dph_q;
      `CMO_SFR_P1  : dir_val = is_rmw ? port1_o : p1_s2_q; // [RULE_15]
      `CMO_SFR_P2  : dir_val = p2_q;                       // [RULE_15]
      default      : dir_val = 8'h00;
    endcase
  bit_val = dir_val[opr1_q[2:0]];
end

// ==========================================================
// pin synchronisers and internal ram write
always @(posedge clk or negedge nrst)
begin
  if (!nrst)
  begin
    lad_s1_q <= 8'h00;
    lad_s2_q <= 8'h00;
    p1_s1_q  <= 8'h00;
    p1_s2_q  <= 8'h00;
  end
  else
  begin
    lad_s1_q <= low_addr_data_port_i;
    lad_s2_q <= lad_s1_q;
    p1_s1_q  <= port1_i;
    p1_s2_q  <= p1_s1_q;
  end
end

// ram is not reset; software owns its contents
always @(posedge clk)
begin
  if (iw_en_q)
    iram[iw_a_q] <= iw_d_q;
end

// high port shows pointer high byte only during a pointer access
always @(posedge clk or negedge nrst)
begin
  if (!nrst)
    high_address_port <= `CMO_PORT_RST;
  else
    high_address_port <= xdp_q ? dph_q : p2_q; // [RULE_06] [RULE_07]
end

// ==========================================================
// direct write: ram below 0x80, special registers above
task dir_write;
  input [7:0] a;
  input [7:0] v;
  begin
    if (!a[7])
    begin
      iw_en_q <= 1'b1;
      iw_a_q  <= a;
      iw_d_q  <= v;
    end
    else
      case (a)
        `CMO_SFR_A   : acc_q   <= v;
        `CMO_SFR_B   : b_q     <= v;
        `CMO_SFR_PSW : psw_q   <= v;
        `CMO_SFR_SP  : sp_q    <= v;
        `CMO_SFR_DPL : dpl_q   <= v;
        `CMO_SFR_DPH : dph_q   <= v;
        `CMO_SFR_P1  : port1_o <= v;
        `CMO_SFR_P2  : p2_q    <= v;
        default      : iw_en_q <= 1'b0;
      endcase
  end
endtask

// ==========================================================
// instruction sequencer; each instruction holds cyc_q machine cycles
always @(posedge clk or negedge nrst)
begin
  if (!nrst)
  begin
    st_q <= ST_ADDR;
    cnt_q <= 7'd0;
    idx_q <= 2'd0;
    op_q <= 8'h00;
    opr1_q <= 8'h00;
    opr2_q <= 8'h00;
    len_q <= 2'd1;
    cyc_q <= 3'd1;
    sub_q <= 3'd0;
    xdp_q <= 1'b0;
    pc_q <= 16'h0000;
    acc_q <= 8'h00;
    b_q <= 8'h00;
    psw_q <= 8'h00;
    sp_q <= `CMO_SP_RST;
    dpl_q <= 8'h00;
    dph_q <= 8'h00;
    p2_q <= `CMO_PORT_RST;
    port1_o <= `CMO_PORT_RST;
    iw_en_q <= 1'b0;
    iw_a_q <= 8'h00;
    iw_d_q <= 8'h00;
    code_addr <= 16'h0000;
    low_addr_data_port_o <= 8'h00;
    low_addr_data_port_oe <= 1'b0;
    addr_latch_en <= 1'b0;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
  end
  else
  begin
    iw_en_q <= 1'b0;
    cnt_q <= (st_q == ST_ADDR && idx_q == 2'd0 && !run_q) ? 7'd0 : cnt_q + 7'd1;
    case (st_q)
      ST_ADDR:
      begin
        if (run_q || idx_q != 2'd0)
        begin
          code_addr <= pc_q;
          st_q <= ST_GAP;
        end
      end
      ST_GAP:
        st_q <= ST_TAKE;
      // take a code byte; the first one sets length and cycle count
      ST_TAKE:
      begin
        pc_q <= pc_q + 16'h0001; // [RULE_12]
        if (idx_q == 2'd0)
        begin
          op_q <= code_data; // [RULE_22]
          len_q <= info_new[4:3];
          cyc_q <= info_new[2:0];
        end
        else if (idx_q == 2'd1)
          opr1_q <= code_data;
        else
          opr2_q <= code_data;
        if ((idx_q == 2'd0 ? info_new[4:3] : len_q) > idx_q + 2'd1)
        begin
          idx_q <= idx_q + 2'd1; // [RULE_22]
          st_q <= ST_ADDR;
        end
        else
        begin
          idx_q <= 2'd0;
          st_q <= ST_EXEC;
        end
      end
      ST_EXEC:
      begin
        st_q <= ST_DONE;
        sub_q <= 3'd0;
        casez (op_q)
          `CMO_OP_CODE_DP:
          begin
            code_addr <= data_pointer + {8'h00, acc_q}; // [RULE_01] [RULE_02]
            st_q <= ST_CODE;
          end
          // pc already points past this opcode
          `CMO_OP_CODE_PC:
          begin
            code_addr <= pc_q + {8'h00, acc_q}; // [RULE_01] [RULE_02]
            st_q <= ST_CODE;
          end
          `CMO_OP_XRD_DP, `CMO_OP_XWR_DP:
          begin
            low_addr_data_port_o <= dpl_q; // [RULE_06]
            low_addr_data_port_oe <= 1'b1;
            addr_latch_en <= 1'b1;
            xdp_q <= 1'b1;
            st_q <= ST_XMEM;
          end
          `CMO_OP_XRD_RI, `CMO_OP_XWR_RI:
          begin
            low_addr_data_port_o <= ri_val; // [RULE_05]
            low_addr_data_port_oe <= 1'b1;
            addr_latch_en <= 1'b1;
            st_q <= ST_XMEM;
          end
          `CMO_OP_MUL:
          begin
            acc_q <= prod[7:0]; // [RULE_10]
            b_q <= prod[15:8];  // [RULE_10]
            psw_q[`CMO_PSW_OV] <= |prod[15:8]; // [RULE_11]
            psw_q[`CMO_PSW_CY] <= 1'b0;        // [RULE_11]
          end
          `CMO_OP_OR_ARN : acc_q <= acc_q | rn_val;  // [RULE_13] [RULE_14]
          `CMO_OP_OR_ADIR: acc_q <= acc_q | dir_val; // [RULE_14]
          `CMO_OP_OR_ARI : acc_q <= acc_q | at_ri;   // [RULE_14]
          `CMO_OP_OR_AIMM: acc_q <= acc_q | opr1_q;  // [RULE_14]
          `CMO_OP_OR_DA  : dir_write(opr1_q, dir_val | acc_q);  // [RULE_13] [RULE_15]
          `CMO_OP_OR_DIMM: dir_write(opr1_q, dir_val | opr2_q); // [RULE_14] [RULE_15]
          `CMO_OP_OR_CBIT:
            if (bit_val)
              psw_q[`CMO_PSW_CY] <= 1'b1; // [RULE_17]
          // the addressed bit itself is only read
          `CMO_OP_OR_CNBIT:
            if (!bit_val)
              psw_q[`CMO_PSW_CY] <= 1'b1; // [RULE_18]
          // decrement first so a popped stack pointer value overrides it
          `CMO_OP_POP:
          begin
            sp_q <= sp_q - 8'd1;      // [RULE_19] [RULE_20]
            dir_write(opr1_q, at_sp); // [RULE_19] [RULE_20]
          end
          `CMO_OP_PUSH:
          begin
            sp_q <= sp_q + 8'd1; // [RULE_21]
            iw_en_q <= 1'b1;
            iw_a_q <= sp_q + 8'd1; // [RULE_21]
            iw_d_q <= dir_val;
          end
          default: st_q <= ST_DONE;
        endcase
      end
      // code byte arrives one clock after its address
      ST_CODE:
      begin
        sub_q <= sub_q + 3'd1;
        if (sub_q != 3'd0)
        begin
          acc_q <= code_data; // [RULE_01]
          st_q <= ST_DONE;
        end
      end
      // address phase, then strobe phase; read data sampled at strobe end
      ST_XMEM:
      begin
        sub_q <= sub_q + 3'd1;
        if (sub_q == `CMO_XM_ALE_END)
          addr_latch_en <= 1'b0; // [RULE_23]
        if (sub_q == `CMO_XM_STB)
        begin
          if (op_q[4])
          begin
            low_addr_data_port_o <= acc_q; // [RULE_04]
            wr_n <= 1'b0;
          end
          else
          begin
            low_addr_data_port_oe <= 1'b0;
            rd_n <= 1'b0;
          end
        end
        if (sub_q == `CMO_XM_END)
        begin
          if (!op_q[4])
            acc_q <= lad_s2_q; // [RULE_04]
          rd_n <= 1'b1;
          wr_n <= 1'b1;
        end
        if (sub_q == `CMO_XM_REL)
        begin
          low_addr_data_port_oe <= 1'b0;
          xdp_q <= 1'b0;
          st_q <= ST_DONE;
        end
      end
      // pad out to the documented machine cycle count
      ST_DONE:
      begin
        if (cnt_q >= last_clk)
        begin
          cnt_q <= 7'd0;
          st_q <= ST_ADDR; // [RULE_03] [RULE_08] [RULE_09] [RULE_16]
        end
      end
      default: st_q <= ST_ADDR;
    endcase
  end
end

// ==========================================================
// apb slave: zero wait states, read data loaded in the setup cycle
assign pready = 1'b1;
wire mapped = (paddr == `CMO_REG_CTRL) || (paddr == `CMO_REG_CORE) ||
              (paddr == `CMO_REG_PTRS) || (paddr == `CMO_REG_PORTS);
assign pslverr = psel && penable && !mapped;

always @(posedge clk or negedge nrst)
begin
  if (!nrst)
  begin
    run_q  <= 1'b0;
    prdata <= 32'h0000_0000;
  end
  else
  begin
    if (psel && penable && pwrite && paddr == `CMO_REG_CTRL)
      run_q <= pwdata[0];
    if (psel && !penable)
      case (paddr)
        `CMO_REG_CTRL : prdata <= {31'h0000_0000, run_q};
        `CMO_REG_CORE : prdata <= {pc_q, acc_q, b_q};
        `CMO_REG_PTRS : prdata <= {dph_q, dpl_q, sp_q, psw_q};
        `CMO_REG_PORTS: prdata <= {8'h00, p2_q, port1_o, 5'h00, st_q};
        default       : prdata <= 32'h0000_0000;
      endcase
  end
end

endmodule

// ---- bench/cmo_core_sva.sv ----
`timescale 1ns/10ps
// ==========================================================
// external bus and register bus checker
module cmo_core_chk (
  // clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // register bus
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // external data bus
  input wire logic [7:0] low_addr_data_port_o,
  input wire logic       low_addr_data_port_oe,
  input wire logic [7:0] high_address_port,
  input wire logic       addr_latch_en,
  input wire logic       rd_n,
  input wire logic       wr_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // address strobe is two clocks wide, so the latch always sees a settled address
  ale_pulse_a: assert property ($rose(addr_latch_en) |=> addr_latch_en ##1 !addr_latch_en)
    else $error("address strobe width wrong");
  addr_hold_a: assert property ($rose(addr_latch_en) |-> low_addr_data_port_oe ##1
    ($stable(low_addr_data_port_o) && low_addr_data_port_oe)[*2])
    else $error("low address not held while latched");
  wr_pulse_a: assert property ($fell(wr_n) |=> !wr_n[*3] ##1 wr_n)
    else $error("write strobe width wrong");
  rd_pulse_a: assert property ($fell(rd_n) |=> !rd_n[*3] ##1 rd_n)
    else $error("read strobe width wrong");
  strobe_order_a: assert property (($fell(rd_n) || $fell(wr_n)) |->
    !addr_latch_en && $past(addr_latch_en, 2))
    else $error("data strobe without address phase");
  wdata_hold_a: assert property ((!wr_n && !$past(wr_n)) |->
    low_addr_data_port_oe && $stable(low_addr_data_port_o))
    else $error("write data moved under strobe");
  rd_release_a: assert property (!rd_n |-> !low_addr_data_port_oe && wr_n)
    else $error("bus driven during read");
  // the high port goes back to its own latch value once the move is over
  p2_restore_a: assert property ($rose(addr_latch_en) |->
    ##12 (high_address_port == $past(high_address_port, 12)))
    else $error("high port latch disturbed by move");
  apb_err_a: assert property (pslverr |-> psel && penable)
    else $error("error response outside access phase");
  apb_ready_a: assert property (psel && penable |-> pready)
    else $error("register access stalled");

  wr_seen_c: cover property ($fell(wr_n));
  rd_seen_c: cover property ($fell(rd_n));
  err_seen_c: cover property (pslverr);
endmodule

// ---- bench/cmo_xram.sv ----
`timescale 1ns/10ps
// ==========================================================
// external data ram on the multiplexed low port
module cmo_xram (
  // strobes
  input wire logic       clk,
  input wire logic       addr_latch_en,
  input wire logic       rd_n,
  input wire logic       wr_n,
  // address and data from the core
  input wire logic       low_addr_data_port_oe,
  input wire logic [7:0] low_addr_data_port_o,
  input wire logic [7:0] high_address_port,
  // resolved bus level
  output logic [7:0]     bus
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr_q = 16'h0000;
  logic        ale_q  = 1'b0;
  logic        wr_q   = 1'b1;
  logic [7:0]  last_q = 8'h00;

  // address taken as the strobe falls, data moved only under the strobes
  always @(posedge clk)
  begin
    ale_q <= addr_latch_en;
    wr_q  <= wr_n;
    if (ale_q && !addr_latch_en)
      addr_q <= {high_address_port, low_addr_data_port_o};
    if (!wr_q && wr_n)
      mem[addr_q] <= low_addr_data_port_o;
    if (!rd_n)
      last_q <= mem[addr_q];
  end

  // released bus shows the inverse of the last byte, never a stale copy
  assign bus = low_addr_data_port_oe ? low_addr_data_port_o :
               (!rd_n ? mem[addr_q] : ~last_q);
endmodule

// ---- bench/cmo_core_tb_top.sv ----
`timescale 1ns/10ps
module cmo_core_tb_top;
  // ==========================================================
  // stimulus and wiring
  logic        clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00, code_data = 8'h00, p1_pins = 8'h3C;
  logic [31:0] pwdata = 32'h0000_0000, r04, r08, r0c;
  wire  [31:0] prdata;
  wire  [15:0] code_addr;
  wire  [7:0]  lad_o, hi_port, p1_o, bus;
  wire         pready, pslverr, lad_oe, ale, rd_n, wr_n;
  logic [7:0]  code_mem [0:65535];
  int          miscompares = 0, n_compared = 0;

  always #10 clk = ~clk;
  // program memory answers one clock after the address
  always @(posedge clk) code_data <= code_mem[code_addr];

  // clocks between the last two read strobe falls, used to time instructions
  logic rd_d = 1'b1;
  int   since = 0, gap = 0;
  always @(posedge clk)
  begin
    rd_d <= rd_n;
    since <= (rd_d && !rd_n) ? 1 : since + 1;
    if (rd_d && !rd_n)
      gap <= since;
  end

  cmo_core uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .code_addr(code_addr), .code_data(code_data), .low_addr_data_port_o(lad_o),
    .low_addr_data_port_oe(lad_oe), .low_addr_data_port_i(bus), .high_address_port(hi_port),
    .addr_latch_en(ale), .rd_n(rd_n), .wr_n(wr_n), .port1_o(p1_o), .port1_i(p1_pins));
  cmo_xram xram (.clk(clk), .addr_latch_en(ale), .rd_n(rd_n), .wr_n(wr_n),
    .low_addr_data_port_oe(lad_oe), .low_addr_data_port_o(lad_o),
    .high_address_port(hi_port), .bus(bus));

  // ==========================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer, request held until pready is seen at an edge; a hang is left to the watchdog
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // load a program, reset, run it, stop and fetch the core state
  task automatic run_prog(input logic [7:0] p[$]);
    logic [31:0] d;
    logic        e;
    for (int i = 0; i < 256; i++) code_mem[i] = 8'h00;
    foreach (p[i]) code_mem[i] = p[i];
    nrst <= 0;
    repeat (2) @(posedge clk);
    nrst <= 1;
    apb(1, 8'h00, 32'h0000_0001, d, e);
    repeat (400) @(posedge clk);
    apb(1, 8'h00, 32'h0000_0000, d, e);
    apb(0, 8'h04, 32'h0000_0000, r04, e);
    apb(0, 8'h08, 32'h0000_0000, r08, e);
    apb(0, 8'h0C, 32'h0000_0000, r0c, e);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs;
    logic [31:0] d;
    logic        e;
    apb(0, 8'h0C, 32'h0000_0000, d, e);
    chk("port_latches", d & 32'hFFFF_FFF8, 32'h00FF_FF00);
    apb(1, 8'h04, 32'hFFFF_FFFF, d, e);
    apb(0, 8'h04, 32'h0000_0000, d, e);
    chk("core_readonly", d, 32'h0000_0000);
    apb(0, 8'h40, 32'h0000_0000, d, e);
    chk("unmapped_err", e, 1);
    chk("unmapped_data", d, 0);
  endtask

  task automatic t_mul;
    logic [7:0]  ca [3] = '{8'h50, 8'h0F, 8'hFF};
    logic [7:0]  cb [3] = '{8'hA0, 8'h11, 8'hFF};
    logic [15:0] prod;
    for (int i = 0; i < 3; i++)
    begin
      prod = ca[i] * cb[i];
      run_prog('{8'h43, 8'hD0, 8'h80, 8'h44, ca[i], 8'h43, 8'hF0, cb[i], 8'hA4});
      chk("mul_low", r04[15:8], prod[7:0]);
      chk("mul_high", r04[7:0], prod[15:8]);
      chk("mul_ov", r08[2], prod > 16'd255);
      chk("mul_cy", r08[7], 0);
    end
  endtask

  task automatic t_code_byte_load;
    // offsets chosen so that the low byte carries into the high byte
    run_prog('{8'h43, 8'h83, 8'h01, 8'h43, 8'h82, 8'hFE, 8'h44, 8'h05, 8'h93});
    chk("code_byte_load_ptr", r04[15:8], 8'h5A);
    chk("ptr_kept", r08[31:16], 16'h01FE);
    run_prog('{8'h44, 8'hFE, 8'h83});
    chk("code_byte_load_pc", r04[15:8], 8'hA7);
  endtask

  task automatic t_xmove;
    xram.mem[16'hFF6C] = 8'h9D;
    xram.mem[16'h123C] = 8'h77;
    run_prog('{8'h43, 8'h83, 8'h12, 8'h43, 8'h82, 8'h34, 8'h44, 8'h6C, 8'hF0,
      8'h43, 8'h81, 8'hFF, 8'hC0, 8'hE0, 8'hE2, 8'hF0, 8'h43, 8'h82, 8'h08, 8'hE0, 8'hF2});
    chk("xrd_ptr", r04[15:8], 8'h77);
    chk("xwr_ptr", xram.mem[16'h1234], 8'h9D);
    chk("xwr_idx", xram.mem[16'hFF6C], 8'h77);
    chk("ptr_value", r08[31:16], 16'h123C);
    chk("p2_latch", r0c[23:16], 8'hFF);
    chk("sp_wrap", r08[15:8], 8'h00);
  endtask

  task automatic t_orl_byte;
    run_prog('{8'h43, 8'h81, 8'hFF, 8'h43, 8'h82, 8'h30, 8'hC0, 8'h82, 8'h43, 8'hF0, 8'h84,
      8'h44, 8'h01, 8'h48, 8'h42, 8'hF0, 8'h45, 8'hF0});
    chk("or_acc", r04[15:8], 8'hB5);
    chk("or_direct", r04[7:0], 8'hB5);
    chk("or_flags", r08[7:0] & 8'h84, 8'h00);
  endtask

  task automatic t_orl_port;
    run_prog('{8'h43, 8'h90, 8'h01});
    chk("port_latch", p1_o, 8'hFF);
    chk("port_reg", r0c[15:8], 8'hFF);
  endtask

  task automatic t_orl_bit;
    logic [7:0] op [4] = '{8'hA0, 8'hA0, 8'h72, 8'h72};
    logic [7:0] ba [4] = '{8'hE7, 8'hE6, 8'hE7, 8'hE6};
    logic       cy [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++)
    begin
      run_prog('{8'h44, 8'h80, op[i], ba[i]});
      chk("bit_or_cy", r08[7], cy[i]);
      chk("bit_kept", r04[15:8], 8'h80);
    end
  endtask

  task automatic t_stack;
    run_prog('{8'h44, 8'h20, 8'h43, 8'h81, 8'h30, 8'hC0, 8'hE0, 8'h44, 8'h03, 8'hC0, 8'hE0,
      8'hD0, 8'h82, 8'hD0, 8'h81});
    chk("pop_dst", r08[23:16], 8'h23);
    chk("pop_sp", r08[15:8], 8'h20);
    chk("acc_kept", r04[15:8], 8'h23);
  endtask

  // two reads bracket one instruction: strobe spacing is 12 clocks per machine cycle
  task automatic t_timing;
    xram.mem[16'h0000] = 8'h01;
    run_prog('{8'hE0, 8'hE0});
    chk("xmove_clks", gap, 2 * 12);
    run_prog('{8'hE0, 8'hA4, 8'hE0});
    chk("mul_clks", gap, (2 + 4) * 12);
    run_prog('{8'hE0, 8'h00, 8'hE0});
    chk("idle_clks", gap, (2 + 1) * 12);
    run_prog('{8'hE0, 8'h83, 8'hE0});
    chk("code_byte_load_clks", gap, (2 + 2) * 12);
    run_prog('{8'hE0, 8'h43, 8'h90, 8'h00, 8'hE0});
    chk("or_imm_clks", gap, (2 + 2) * 12);
    run_prog('{8'hE0, 8'h46, 8'hE0});
    chk("or_ind_clks", gap, (2 + 1) * 12);
    run_prog('{8'hE0, 8'h72, 8'hE7, 8'hE0});
    chk("bit_or_clks", gap, (2 + 2) * 12);
    run_prog('{8'hE0, 8'hC0, 8'hE0, 8'hE0});
    chk("push_clks", gap, (2 + 2) * 12);
  endtask

  // ==========================================================
  // verdict and run control
  task automatic summarize;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #1_000_000;
    miscompares++;
    summarize;
  end

  initial
  begin
    for (int i = 0; i < 65536; i++) code_mem[i] = 8'h00;
    code_mem[16'h0203] = 8'h5A;
    code_mem[16'h0101] = 8'hA7;
    repeat (16) @(posedge clk);
    nrst <= 1;
    t_regs;
    t_mul;
    t_code_byte_load;
    t_xmove;
    t_orl_byte;
    t_orl_port;
    t_orl_bit;
    t_stack;
    t_timing;
    summarize;
  end
endmodule

bind cmo_core cmo_core_chk chk_i (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .low_addr_data_port_o(low_addr_data_port_o),
  .low_addr_data_port_oe(low_addr_data_port_oe), .high_address_port(high_address_port),
  .addr_latch_en(addr_latch_en), .rd_n(rd_n), .wr_n(wr_n));
